/* src/tel_bp_trig.sv */
// Breakpoint trigger qualifier for one breakpoint unit (data or instruction).
// Assumes hit flags are valid in the cycle of the completing instruction.
`timescale 1ns/1ps
module tel_bp_trig
	import tel_pkg::*;
(
	input wire logic [TEL_NBP-1:0] trace_trigger_enable_i,
	input wire logic [TEL_NBP-1:0] debug_break_enable_i,
	input wire logic [TEL_NBP-1:0] breakpoint_hit_flags_i,
	input wire logic trace_gate_i,
	input wire logic [TEL_NBP-1:0] start_select_i,
	output logic start_o,
	output logic stop_o,
	output logic [TEL_NBP-1:0] debug_exc_o
);
	logic [TEL_NBP-1:0] fire;

	always_comb begin
		fire = trace_trigger_enable_i & breakpoint_hit_flags_i & {TEL_NBP{trace_gate_i}};
		start_o = |(fire & start_select_i);
		stop_o = |(fire & ~start_select_i);
		// Only the break enable raises an exception; a trace trigger alone stays internal.
		debug_exc_o = breakpoint_hit_flags_i & debug_break_enable_i;
	end
endmodule

/* src/tel_pkg.sv */
// Package for the trace enable logic: widths, register offsets, field positions and carriers.
// Assumes a 32-bit classic Wishbone register bus and one processor clock.
package tel_pkg;

	localparam int TEL_ADDRESS_SPACE_TAG_W = 8;
	localparam int TEL_ID_W = 8;
	localparam int TEL_NBP = 4;

	// Register byte offsets.
	localparam logic [7:0] TEL_OFF_SW_CTRL = 8'h00;
	localparam logic [7:0] TEL_OFF_SW_CTRL2 = 8'h04;
	localparam logic [7:0] TEL_OFF_BP_ACTION = 8'h08;
	localparam logic [7:0] TEL_OFF_BP_CTRL = 8'h0c;
	localparam logic [7:0] TEL_OFF_STATUS = 8'h10;
	localparam logic [7:0] TEL_OFF_HW_A = 8'h14;
	localparam logic [7:0] TEL_OFF_HW_B = 8'h18;
	localparam logic [7:0] TEL_OFF_HW_C = 8'h1c;

	// Mode select field: bit 0 user, 1 supervisor, 2 kernel, 3 exception, 4 debug.
	localparam int TEL_MODE_W = 5;

	// Software control word layout.
	localparam int TEL_SW_ON = 0;
	localparam int TEL_SW_SRC = 1;
	localparam int TEL_SW_G = 2;
	localparam int TEL_SW_MODE_LO = 3;
	localparam int TEL_SW_ADDRESS_SPACE_TAG_LO = 8;

	// Filter word layout (software control 2 and hardware control C).
	localparam int TEL_F_TCV = 0;
	localparam int TEL_F_VPV = 1;
	localparam int TEL_F_TCN_LO = 8;
	localparam int TEL_F_VPN_LO = 16;

	// Breakpoint action word layout.
	localparam int TEL_BA_DE = 0;
	localparam int TEL_BA_IE = 1;
	localparam int TEL_BA_DON_LO = 8;
	localparam int TEL_BA_ION_LO = 16;

	// Breakpoint control word: trace trigger and debug break enables per breakpoint.
	localparam int TEL_BC_DTE_LO = 0;
	localparam int TEL_BC_DBE_LO = 8;
	localparam int TEL_BC_ITE_LO = 16;
	localparam int TEL_BC_IBE_LO = 24;

	// Status word layout.
	localparam int TEL_ST_ON = 0;
	localparam int TEL_ST_MATCH = 1;
	localparam int TEL_ST_START = 2;
	localparam int TEL_ST_STOP = 3;
	localparam int TEL_ST_GATE = 4;
	localparam int TEL_ST_OFFCHIP = 5;

	// Hardware control B layout.
	localparam int TEL_B_GATE = 0;
	localparam int TEL_B_OFFCHIP = 1;

	localparam logic [31:0] TEL_RST_WORD = 32'h0000_0000;

	// One control set as the qualifier sees it.
	typedef struct packed {
		logic on;
		logic global_bit;
		logic [TEL_MODE_W-1:0] mode_sel;
		logic [TEL_ADDRESS_SPACE_TAG_W-1:0] address_space_tag;
		logic thread_filter_valid;
		logic [TEL_ID_W-1:0] thread_filter_number;
		logic vpe_filter_valid;
		logic [TEL_ID_W-1:0] vpe_filter_number;
	} tel_ctrl_set_t;

	// Completed instruction as the pipeline reports it.
	typedef struct packed {
		logic valid;
		logic [TEL_ID_W-1:0] tc_id;
		logic [TEL_ID_W-1:0] vpe_id;
		logic [TEL_MODE_W-1:0] mode;
		logic [TEL_ADDRESS_SPACE_TAG_W-1:0] current_address_space_tag_reg;
	} tel_instr_t;

	// Breakpoint hits from the breakpoint units.
	typedef struct packed {
		logic [TEL_NBP-1:0] data_hit;
		logic [TEL_NBP-1:0] instr_hit;
	} tel_bp_hits_t;

endpackage

/* src/tel_trace_enable.sv */
// Trace on/off qualification with a Wishbone register file and capture unit gating.
// Assumes pipeline and breakpoint inputs are synchronous to clk_i at 20 MHz.
`timescale 1ns/1ps
module tel_trace_enable
	import tel_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic debug_port_reset_n_i,
	input wire logic tap_logic_reset_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire tel_instr_t instr_i,
	input wire tel_bp_hits_t bp_hits_i,
	input wire logic gate_set_i,
	input wire logic gate_clr_i,
	input wire logic trace_data_valid_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic trace_on_o,
	output logic onchip_valid_o,
	output logic offchip_valid_o,
	output logic [TEL_NBP-1:0] data_debug_exc_o,
	output logic [TEL_NBP-1:0] instr_debug_exc_o
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [31:0] sw_ctrl;
		logic [31:0] sw_ctrl2;
		logic [31:0] bp_action;
		logic [31:0] bp_ctrl;
		logic [31:0] hw_a;
		logic [31:0] hw_b;
		logic [31:0] hw_c;
		logic [31:0] dat;
		logic ack;
		logic trace_on;
		logic match;
		logic start;
		logic stop;
		logic onchip;
		logic offchip;
		logic [TEL_NBP-1:0] dexc;
		logic [TEL_NBP-1:0] iexc;
	} tel_state_t;

	tel_state_t state_ff;
	tel_state_t nxt_state;

	tel_ctrl_set_t sw_set;
	tel_ctrl_set_t hw_set;
	tel_ctrl_set_t sel_set;
	logic src_sw;
	logic id_ok;
	logic address_space_tag_ok;
	logic mode_ok;
	logic match;
	logic d_start;
	logic d_stop;
	logic i_start;
	logic i_stop;
	logic start_hit;
	logic stop_hit;
	logic [TEL_NBP-1:0] d_exc;
	logic [TEL_NBP-1:0] i_exc;
	logic cap_rst;
	logic wr;
	logic [31:0] wmask;

	////////////////////////////////////////////////////////////////////////////////
	// Breakpoint trigger units.

	tel_bp_trig u_data_bp (
		.trace_trigger_enable_i(state_ff.bp_ctrl[TEL_BC_DTE_LO +: TEL_NBP]),
		.debug_break_enable_i(state_ff.bp_ctrl[TEL_BC_DBE_LO +: TEL_NBP]),
		.breakpoint_hit_flags_i(bp_hits_i.data_hit),
		.trace_gate_i(state_ff.bp_action[TEL_BA_DE]),
		.start_select_i(state_ff.bp_action[TEL_BA_DON_LO +: TEL_NBP]),
		.start_o(d_start),
		.stop_o(d_stop),
		.debug_exc_o(d_exc)
	);

	tel_bp_trig u_instr_bp (
		.trace_trigger_enable_i(state_ff.bp_ctrl[TEL_BC_ITE_LO +: TEL_NBP]),
		.debug_break_enable_i(state_ff.bp_ctrl[TEL_BC_IBE_LO +: TEL_NBP]),
		.breakpoint_hit_flags_i(bp_hits_i.instr_hit),
		.trace_gate_i(state_ff.bp_action[TEL_BA_IE]),
		.start_select_i(state_ff.bp_action[TEL_BA_ION_LO +: TEL_NBP]),
		.start_o(i_start),
		.stop_o(i_stop),
		.debug_exc_o(i_exc)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Qualification.

	always_comb begin
		sw_set.on = state_ff.sw_ctrl[TEL_SW_ON];
		sw_set.global_bit = state_ff.sw_ctrl[TEL_SW_G];
		sw_set.mode_sel = state_ff.sw_ctrl[TEL_SW_MODE_LO +: TEL_MODE_W];
		sw_set.address_space_tag = state_ff.sw_ctrl[TEL_SW_ADDRESS_SPACE_TAG_LO +: TEL_ADDRESS_SPACE_TAG_W];
		sw_set.thread_filter_valid = state_ff.sw_ctrl2[TEL_F_TCV];
		sw_set.thread_filter_number = state_ff.sw_ctrl2[TEL_F_TCN_LO +: TEL_ID_W];
		sw_set.vpe_filter_valid = state_ff.sw_ctrl2[TEL_F_VPV];
		sw_set.vpe_filter_number = state_ff.sw_ctrl2[TEL_F_VPN_LO +: TEL_ID_W];
		hw_set.on = state_ff.hw_a[TEL_SW_ON];
		hw_set.global_bit = state_ff.hw_a[TEL_SW_G];
		hw_set.mode_sel = state_ff.hw_a[TEL_SW_MODE_LO +: TEL_MODE_W];
		hw_set.address_space_tag = state_ff.hw_a[TEL_SW_ADDRESS_SPACE_TAG_LO +: TEL_ADDRESS_SPACE_TAG_W];
		hw_set.thread_filter_valid = state_ff.hw_c[TEL_F_TCV];
		hw_set.thread_filter_number = state_ff.hw_c[TEL_F_TCN_LO +: TEL_ID_W];
		hw_set.vpe_filter_valid = state_ff.hw_c[TEL_F_VPV];
		hw_set.vpe_filter_number = state_ff.hw_c[TEL_F_VPN_LO +: TEL_ID_W];
		src_sw = state_ff.sw_ctrl[TEL_SW_SRC];
		sel_set = src_sw ? sw_set : hw_set;
		if (sel_set.thread_filter_valid) begin
			id_ok = (sel_set.thread_filter_number == instr_i.tc_id);
		end else if (sel_set.vpe_filter_valid) begin
			id_ok = (sel_set.vpe_filter_number == instr_i.vpe_id);
		end else begin
			id_ok = 1'b1;
		end
		if (src_sw) begin
			// Software path: tag bits set in the control set are don't-care.
			address_space_tag_ok = sel_set.global_bit
				|| (((sel_set.address_space_tag ^ instr_i.current_address_space_tag_reg) & ~sel_set.address_space_tag) == '0);
		end else begin
			address_space_tag_ok = sel_set.global_bit || (sel_set.address_space_tag == instr_i.current_address_space_tag_reg);
		end
		mode_ok = |(sel_set.mode_sel & instr_i.mode);
		match = id_ok && address_space_tag_ok && mode_ok;
		start_hit = d_start || i_start;
		stop_hit = d_stop || i_stop;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		cap_rst = !debug_port_reset_n_i || tap_logic_reset_i;
		wr = cyc_i && stb_i && we_i && !state_ff.ack;
		wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
		nxt_state = state_ff;
		nxt_state.ack = cyc_i && stb_i && !state_ff.ack;
		nxt_state.dexc = d_exc;
		nxt_state.iexc = i_exc;
		if (instr_i.valid) begin
			// Only a completed instruction re-evaluates; otherwise the state holds.
			nxt_state.match = match;
			nxt_state.start = start_hit;
			nxt_state.stop = stop_hit;
			if (sel_set.on && (match || start_hit)) begin
				nxt_state.trace_on = 1'b1;
			end else if (!sel_set.on || stop_hit) begin
				nxt_state.trace_on = 1'b0;
			end
		end
		if (wr) begin
			if (adr_i == TEL_OFF_SW_CTRL) begin
				nxt_state.sw_ctrl = (state_ff.sw_ctrl & ~wmask) | (dat_i & wmask);
			end else if (adr_i == TEL_OFF_SW_CTRL2) begin
				nxt_state.sw_ctrl2 = (state_ff.sw_ctrl2 & ~wmask) | (dat_i & wmask);
			end else if (adr_i == TEL_OFF_BP_ACTION) begin
				nxt_state.bp_action = (state_ff.bp_action & ~wmask) | (dat_i & wmask);
			end else if (adr_i == TEL_OFF_BP_CTRL) begin
				nxt_state.bp_ctrl = (state_ff.bp_ctrl & ~wmask) | (dat_i & wmask);
			end else if (adr_i == TEL_OFF_HW_A) begin
				nxt_state.hw_a = (state_ff.hw_a & ~wmask) | (dat_i & wmask);
			end else if (adr_i == TEL_OFF_HW_B) begin
				nxt_state.hw_b = (state_ff.hw_b & ~wmask) | (dat_i & wmask);
			end else if (adr_i == TEL_OFF_HW_C) begin
				nxt_state.hw_c = (state_ff.hw_c & ~wmask) | (dat_i & wmask);
			end
		end
		// Trigger set wins over both a clear trigger and a software write.
		if (gate_clr_i) begin
			nxt_state.hw_b[TEL_B_GATE] = 1'b0;
		end
		if (gate_set_i) begin
			nxt_state.hw_b[TEL_B_GATE] = 1'b1;
		end
		nxt_state.onchip = trace_data_valid_i && state_ff.hw_b[TEL_B_GATE]
			&& !state_ff.hw_b[TEL_B_OFFCHIP];
		nxt_state.offchip = trace_data_valid_i && state_ff.hw_b[TEL_B_GATE]
			&& state_ff.hw_b[TEL_B_OFFCHIP];
		nxt_state.dat = TEL_RST_WORD;
		if (cyc_i && stb_i && !we_i && !state_ff.ack) begin
			if (adr_i == TEL_OFF_SW_CTRL) begin
				nxt_state.dat = state_ff.sw_ctrl;
			end else if (adr_i == TEL_OFF_SW_CTRL2) begin
				nxt_state.dat = state_ff.sw_ctrl2;
			end else if (adr_i == TEL_OFF_BP_ACTION) begin
				nxt_state.dat = state_ff.bp_action;
			end else if (adr_i == TEL_OFF_BP_CTRL) begin
				nxt_state.dat = state_ff.bp_ctrl;
			end else if (adr_i == TEL_OFF_STATUS) begin
				nxt_state.dat[TEL_ST_ON] = state_ff.trace_on;
				nxt_state.dat[TEL_ST_MATCH] = state_ff.match;
				nxt_state.dat[TEL_ST_START] = state_ff.start;
				nxt_state.dat[TEL_ST_STOP] = state_ff.stop;
				nxt_state.dat[TEL_ST_GATE] = state_ff.hw_b[TEL_B_GATE];
				nxt_state.dat[TEL_ST_OFFCHIP] = state_ff.hw_b[TEL_B_OFFCHIP];
			end else if (adr_i == TEL_OFF_HW_A) begin
				nxt_state.dat = state_ff.hw_a;
			end else if (adr_i == TEL_OFF_HW_B) begin
				nxt_state.dat = state_ff.hw_b;
			end else if (adr_i == TEL_OFF_HW_C) begin
				nxt_state.dat = state_ff.hw_c;
			end
		end
		// Capture unit setup survives processor reset so a reset exception can be traced.
		if (cap_rst) begin
			nxt_state.hw_a = TEL_RST_WORD;
			nxt_state.hw_b = TEL_RST_WORD;
			nxt_state.hw_c = TEL_RST_WORD;
			nxt_state.onchip = 1'b0;
			nxt_state.offchip = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff.sw_ctrl <= TEL_RST_WORD;
			state_ff.sw_ctrl2 <= TEL_RST_WORD;
			state_ff.bp_action <= TEL_RST_WORD;
			state_ff.bp_ctrl <= TEL_RST_WORD;
			state_ff.dat <= TEL_RST_WORD;
			state_ff.ack <= 1'b0;
			state_ff.trace_on <= 1'b0;
			state_ff.match <= 1'b0;
			state_ff.start <= 1'b0;
			state_ff.stop <= 1'b0;
			state_ff.dexc <= '0;
			state_ff.iexc <= '0;
			state_ff.hw_a <= nxt_state.hw_a;
			state_ff.hw_b <= nxt_state.hw_b;
			state_ff.hw_c <= nxt_state.hw_c;
			state_ff.onchip <= nxt_state.onchip;
			state_ff.offchip <= nxt_state.offchip;
		end else if (ce_i) begin
			state_ff <= nxt_state;
		end
	end

	always_comb begin
		dat_o = state_ff.dat;
		ack_o = state_ff.ack;
		trace_on_o = state_ff.trace_on;
		onchip_valid_o = state_ff.onchip;
		offchip_valid_o = state_ff.offchip;
		data_debug_exc_o = state_ff.dexc;
		instr_debug_exc_o = state_ff.iexc;
	end

endmodule

/* verif/tel_pipe_model.sv */
// Model of the pipeline and breakpoint units that feed the trace enable block.
// Assumes the caller holds the clock and asks for one retirement at a time.
`timescale 1ns/1ps
module tel_pipe_model
	import tel_pkg::*;
(
	input wire logic clk_i,
	output tel_instr_t instr_o,
	output tel_bp_hits_t hits_o
);
	initial begin
		instr_o = '0;
		hits_o = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Between retirements the instruction fields are inverted and the hits cleared, since only the valid cycle counts.
	task automatic retire(input logic [7:0] tc, input logic [7:0] vp, input logic [4:0] md,
		input logic [7:0] as, input logic [3:0] dh, input logic [3:0] ih);
		@(posedge clk_i);
		instr_o <= {1'b1, tc, vp, md, as};
		hits_o <= {dh, ih};
		@(posedge clk_i);
		instr_o <= {1'b0, ~tc, ~vp, ~md, ~as};
		hits_o <= '0;
	endtask
endmodule

/* verif/tel_trace_enable_checker.sv */
// Port level checks of the trace enable block.
// Assumes one clock and the synchronous active high processor reset.
`timescale 1ns/1ps
module tel_trace_enable_checker
	import tel_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire tel_instr_t instr_i,
	input wire tel_bp_hits_t bp_hits_i,
	input wire logic trace_data_valid_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic trace_on_o,
	input wire logic onchip_valid_o,
	input wire logic offchip_valid_o,
	input wire logic [TEL_NBP-1:0] data_debug_exc_o,
	input wire logic [TEL_NBP-1:0] instr_debug_exc_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_bus_req;
		cyc_i && stb_i && !ack_o && ce_i;
	endsequence
	sequence s_retired;
		$past(instr_i.valid) && $past(ce_i);
	endsequence
	property p_ack_after_req;
		s_bus_req |=> ack_o;
	endproperty
	property p_ack_one;
		ack_o && ce_i |=> !ack_o;
	endproperty
	property p_dat_idle;
		!ack_o |-> dat_o == 32'h0;
	endproperty
	// The trace on state may only move on a retirement or a reset.
	property p_on_needs_instr;
		!$stable(trace_on_o) |-> s_retired or $past(rst_i);
	endproperty
	property p_reset_clears;
		$past(rst_i) |-> !trace_on_o && !ack_o && data_debug_exc_o == '0;
	endproperty
	property p_dexc_hit;
		$past(ce_i) |-> (data_debug_exc_o & ~$past(bp_hits_i.data_hit)) == '0;
	endproperty
	property p_iexc_hit;
		$past(ce_i) |-> (instr_debug_exc_o & ~$past(bp_hits_i.instr_hit)) == '0;
	endproperty
	property p_route_excl;
		!(onchip_valid_o && offchip_valid_o);
	endproperty
	property p_route_src;
		$past(ce_i) && (onchip_valid_o || offchip_valid_o) |-> $past(trace_data_valid_i);
	endproperty
	a_ack_after_req: assert property (p_ack_after_req) else $error("no ack after request");
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
	a_on_needs_instr: assert property (p_on_needs_instr) else $error("trace state moved alone");
	a_reset_clears: assert property (p_reset_clears) else $error("outputs not cleared");
	a_dexc_hit: assert property (p_dexc_hit) else $error("data exception without hit");
	a_iexc_hit: assert property (p_iexc_hit) else $error("instr exception without hit");
	a_route_excl: assert property (p_route_excl) else $error("both routes valid");
	a_route_src: assert property (p_route_src) else $error("route valid without data");
endmodule
bind tel_trace_enable tel_trace_enable_checker tel_trace_enable_checker_i (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .instr_i(instr_i),
	.bp_hits_i(bp_hits_i), .trace_data_valid_i(trace_data_valid_i), .dat_o(dat_o),
	.ack_o(ack_o), .trace_on_o(trace_on_o), .onchip_valid_o(onchip_valid_o),
	.offchip_valid_o(offchip_valid_o), .data_debug_exc_o(data_debug_exc_o),
	.instr_debug_exc_o(instr_debug_exc_o));

/* verif/test_tel_trace_enable.sv */
// Self-checking bench of the trace enable block.
// Assumes the pipeline model and the bound checker sit beside the block.
`timescale 1ns/1ps
module test_tel_trace_enable;
	import tel_pkg::*;
	`define CHK(nm, got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
		$display("wrong value %s exp %h got %h", nm, exp, got); end end
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, dbg_n = 1'b0, tap = 1'b0;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, gs = 1'b0, gc = 1'b0, tdv = 1'b0;
	logic [7:0] adr_i = 8'h0;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	logic ack_o, trace_on_o, onchip_o, offchip_o;
	logic [TEL_NBP-1:0] dexc, iexc;
	tel_instr_t instr;
	tel_bp_hits_t hits;
	int err_total = 0, total_checks = 0;
	logic [8:0] bpv [8] = '{9'h041, 9'h020, 9'h061, 9'h020, 9'h003, 9'h005, 9'h020, 9'h080};
	always #25 clk_i = ~clk_i;
	tel_pipe_model tel_pipe_model_i (.clk_i(clk_i), .instr_o(instr), .hits_o(hits));
	tel_trace_enable tel_trace_enable_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.debug_port_reset_n_i(dbg_n), .tap_logic_reset_i(tap), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .instr_i(instr),
		.bp_hits_i(hits), .gate_set_i(gs), .gate_clr_i(gc), .trace_data_valid_i(tdv),
		.dat_o(dat_o), .ack_o(ack_o), .trace_on_o(trace_on_o), .onchip_valid_o(onchip_o),
		.offchip_valid_o(offchip_o), .data_debug_exc_o(dexc), .instr_debug_exc_o(iexc));
	////////////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// The request is held until ack is seen at an edge, for at most 20 edges.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		if (n >= 20)
			err_total++;
	endtask
	task run(input logic hw, input logic [15:0] c, input logic [23:0] f, input logic [7:0] tc,
		input logic [7:0] vp, input logic [4:0] md, input logic [7:0] as, input logic e);
		xfer(1'b1, hw ? TEL_OFF_HW_A : TEL_OFF_SW_CTRL, {16'h0, c & 16'hfffe});
		tel_pipe_model_i.retire(tc, vp, md, as, 4'h0, 4'h0);
		#1 `CHK("master off", trace_on_o, 1'b0)
		xfer(1'b1, hw ? TEL_OFF_HW_C : TEL_OFF_SW_CTRL2, {8'h0, f});
		xfer(1'b1, hw ? TEL_OFF_HW_A : TEL_OFF_SW_CTRL, {16'h0, c});
		tel_pipe_model_i.retire(tc, vp, md, as, 4'h0, 4'h0);
		#1 `CHK("region", trace_on_o, e)
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(20);
		{rst_i, dbg_n} <= 2'b01;
		xfer(1'b0, TEL_OFF_SW_CTRL, 32'h0);
		`CHK("source select", q, 32'h0)
		run(1'b1, 16'h50f9, 24'h0, 8'h0, 8'h0, 5'h01, 8'h50, 1'b1);
		run(1'b1, 16'h50f9, 24'h0, 8'h0, 8'h0, 5'h01, 8'h5a, 1'b0);
		run(1'b1, 16'h00fd, 24'h000301, 8'h4, 8'h0, 5'h01, 8'h0, 1'b0);
		run(1'b1, 16'h50fd, 24'h0, 8'h0, 8'h0, 5'h01, 8'h5a, 1'b1);
		run(1'b0, 16'h50fb, 24'h0, 8'h0, 8'h0, 5'h01, 8'h5a, 1'b0);
		run(1'b0, 16'h50fb, 24'h0, 8'h0, 8'h0, 5'h01, 8'h10, 1'b1);
		run(1'b0, 16'h00ff, 24'h000301, 8'h3, 8'h0, 5'h01, 8'h0, 1'b1);
		run(1'b0, 16'h00ff, 24'h000301, 8'h4, 8'h0, 5'h01, 8'h0, 1'b0);
		run(1'b0, 16'h00ff, 24'h070002, 8'h0, 8'h7, 5'h01, 8'h0, 1'b1);
		run(1'b0, 16'h00ff, 24'h070002, 8'h0, 8'h6, 5'h01, 8'h0, 1'b0);
		run(1'b0, 16'h00ff, 24'h070303, 8'h3, 8'h6, 5'h01, 8'h0, 1'b1);
		run(1'b0, 16'h00ff, 24'h070303, 8'h4, 8'h7, 5'h01, 8'h0, 1'b0);
		for (int m = 0; m < 5; m++) begin
			run(1'b0, 16'h7 | (16'h8 << m), 24'h0, 8'h0, 8'h0, 5'h1 << m, 8'h0, 1'b1);
			run(1'b0, 16'h7 | (16'h8 << m), 24'h0, 8'h0, 8'h0, 5'h1 << ((m + 1) % 5), 8'h0, 1'b0);
		end
		// Master switch and software source, no mode bits, so only breakpoints steer the state.
		xfer(1'b1, TEL_OFF_SW_CTRL, 32'h3);
		xfer(1'b1, TEL_OFF_BP_CTRL, 32'h10003);
		xfer(1'b1, TEL_OFF_BP_ACTION, 32'h10203);
		for (int i = 0; i < 8; i++) begin
			tel_pipe_model_i.retire(8'h0, 8'h0, 5'h01, 8'h0, bpv[i][8:5], bpv[i][4:1]);
			#1 `CHK("trigger", trace_on_o, bpv[i][0])
			`CHK("no break", dexc, 4'h0)
		end
		xfer(1'b1, TEL_OFF_BP_CTRL, 32'h1010403);
		tel_pipe_model_i.retire(8'h0, 8'h0, 5'h01, 8'h0, 4'h4, 4'h1);
		#1 `CHK("data break", dexc, 4'h4)
		`CHK("instr break", iexc, 4'h1)
		// A stop trigger while the enable is low must leave every state untouched.
		ce_i <= 1'b0;
		tel_pipe_model_i.retire(8'h0, 8'h0, 5'h01, 8'h0, 4'h1, 4'h0);
		ce_i <= 1'b1;
		#1 `CHK("frozen", {trace_on_o, dexc}, 5'h14)
		tdv <= 1'b1;
		xfer(1'b1, TEL_OFF_HW_B, 32'h1);
		tick(2);
		`CHK("onchip", {onchip_o, offchip_o}, 2'b10)
		xfer(1'b1, TEL_OFF_HW_B, 32'h3);
		tick(2);
		`CHK("offchip", {onchip_o, offchip_o}, 2'b01)
		gc <= 1'b1;
		tick(1);
		gc <= 1'b0;
		tick(2);
		`CHK("gate cleared", {onchip_o, offchip_o}, 2'b00)
		gs <= 1'b1;
		tick(1);
		gs <= 1'b0;
		tick(2);
		`CHK("gate set", offchip_o, 1'b1)
		xfer(1'b0, TEL_OFF_STATUS, 32'h0);
		`CHK("status gate", q[TEL_ST_GATE], 1'b1)
		xfer(1'b1, 8'h40, 32'hffffffff);
		xfer(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", q, 32'h0)
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		xfer(1'b0, TEL_OFF_SW_CTRL, 32'h0);
		`CHK("sw after reset", q, 32'h0)
		xfer(1'b0, TEL_OFF_HW_B, 32'h0);
		`CHK("hw kept", q[1:0], 2'b11)
		dbg_n <= 1'b0;
		tick(2);
		dbg_n <= 1'b1;
		xfer(1'b0, TEL_OFF_HW_B, 32'h0);
		`CHK("debug reset", q, 32'h0)
		xfer(1'b1, TEL_OFF_HW_A, 32'h5);
		tap <= 1'b1;
		tick(2);
		tap <= 1'b0;
		xfer(1'b0, TEL_OFF_HW_A, 32'h0);
		`CHK("tap reset", q, 32'h0)
		give_verdict();
	end
	initial begin
		tick(20000);
		err_total++;
		give_verdict();
	end
endmodule
